// ---- core/adc_core_calibration_control.sv ----
// Calibration sequencer for a six-core converter with APB registers.
// Assumes APB master on sys_clk and core samples valid on sampleStrobe.
// What this block does
// - Foreground calibration takes every core offline and outputs mid-code.
// - Background mode keeps data flowing while a spare covers a core.
// - There are six cores, two of them spares.
// - Foreground map: inputs 1..4 use cores 0, 1, 4 and 5.
// - Spare 2 covers core 0 or 1; spare 3 covers core 4 or 5.
// - Each calibration tunes linearity, gain and offset against a reference.
// - Foreground calibration runs after every power-up by itself.
// - A trigger from the pin or the soft field, chosen by a selector.
// - Only one core is under calibration at a time in background.
// - A calibrated core replaces the next active one, endlessly.
// - Trims reset to factory values and may be read and overwritten.
// - Trims exist for offset, gain and termination.
// - Trims are held per core, one word per core and kind.
`timescale 1ns/1ps
module adc_core_calibration_control
    import cal_ctrl_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cal_trigger_pin,
    input wire logic sampleStrobe,
    input wire logic [NUM_CORES*SAMPLE_W-1:0] coreSamples,
    input wire logic [18*TRIM_W-1:0] factoryTrim,
    output logic [NUM_INPUTS*SAMPLE_W-1:0] channelOut,
    output logic [NUM_CORES-1:0] coreCalibrate,
    output logic [18*TRIM_W-1:0] trimOut,
    output logic [7:0] swapSourceDelayOut,
    output logic [7:0] swapMuxDelayOut
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [2:0] ctl;
    logic [7:0] swapSrcDly;
    logic [7:0] swapMuxDly;
    logic [2:0] next_ctl;
    logic [7:0] next_swapSrcDly;
    logic [7:0] next_swapMuxDly;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] idx;
    logic access;
    logic trimHit;
    logic [TRIM_W-1:0] trimRd;
    logic fgDone;
    cal_state_e state;
    logic [CORE_IDX_W-1:0] spare0;
    logic [CORE_IDX_W-1:0] spare1;
    logic [CORE_IDX_W-1:0] target;
    logic [CORE_IDX_W-1:0] target1;

    assign idx = paddr[9:2];
    assign access = psel && penable && !pready;
    assign trimHit = idx >= IDX_TRIM_BASE && idx <= IDX_TRIM_LAST;

    always_comb begin
        next_ctl = ctl;
        next_swapSrcDly = swapSrcDly;
        next_swapMuxDly = swapMuxDly;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (access) begin
            next_pready = 1'b1;
            next_prdata = 32'h0;
            if (idx == IDX_CAL_CONTROL) begin
                next_prdata[2:0] = ctl;
                if (pwrite && pstrb[0]) begin
                    next_ctl = pwdata[2:0];
                end
            end else if (idx == IDX_CAL_STATUS) begin
                next_prdata[STS_FG_DONE] = fgDone;
                next_prdata[STS_BUSY] = state != ST_RUN;
                next_prdata[STS_SPARE_HI:STS_SPARE_LO] = spare0;
                next_prdata[STS_TARGET_HI:STS_TARGET_LO] = target;
                next_pslverr = pwrite;
            end else if (idx == IDX_SWAP_SOURCE_DELAY) begin
                next_prdata[7:0] = swapSrcDly;
                if (pwrite && pstrb[0]) begin
                    next_swapSrcDly = pwdata[7:0];
                end
            end else if (idx == IDX_SWAP_MUX_DELAY) begin
                next_prdata[7:0] = swapMuxDly;
                if (pwrite && pstrb[0]) begin
                    next_swapMuxDly = pwdata[7:0];
                end
            end else if (trimHit) begin
                next_prdata[TRIM_W-1:0] = trimRd;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctl <= CTL_RESET;
            swapSrcDly <= SWAP_DELAY_RESET;
            swapMuxDly <= SWAP_DELAY_RESET;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctl <= next_ctl;
            swapSrcDly <= next_swapSrcDly;
            swapMuxDly <= next_swapMuxDly;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Offset, gain and termination trims per core.
    trim_bank #(.ENTRIES(18)) uTrim (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_n),
        .factoryTrim(factoryTrim),
        .wrEn(access && pwrite && trimHit && pstrb[0]),
        .wrIdx(5'(idx - IDX_TRIM_BASE)),
        .wrData(pwdata[TRIM_W-1:0]),
        .rdIdx(5'(idx - IDX_TRIM_BASE)),
        .rdData(trimRd),
        .trimOut(trimOut)
    );

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    logic trigSel;
    logic trigPrev;
    logic trigRise;
    logic bgMode;
    logic calStart;
    logic calDone;
    logic pend;
    cal_state_e next_state;
    logic next_fgDone;
    logic next_trigPrev;
    logic next_pend;
    logic [CORE_IDX_W-1:0] next_spare0;
    logic [CORE_IDX_W-1:0] next_spare1;
    logic [CORE_IDX_W-1:0] next_target;
    logic [CORE_IDX_W-1:0] next_target1;
    logic bank;
    logic next_bank;

    assign trigSel = ctl[CTL_SRC_SEL] ? cal_trigger_pin
                                      : ctl[CTL_SOFT_TRIG];
    assign trigRise = trigSel && !trigPrev;
    assign bgMode = ctl[CTL_BG_EN] && !ctl[CTL_SRC_SEL]
                    && ctl[CTL_SOFT_TRIG];

    cal_timer #(.CYCLES(CAL_LEN)) uTimer (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_n),
        .start(calStart),
        .done(calDone)
    );

    always_comb begin
        next_state = state;
        next_fgDone = fgDone;
        next_trigPrev = trigSel;
        next_pend = pend;
        next_spare0 = spare0;
        next_spare1 = spare1;
        next_target = target;
        next_target1 = target1;
        next_bank = bank;
        calStart = 1'b0;
        unique case (state)
            ST_FG_CAL: begin
                if (calDone) begin
                    next_state = ST_RUN;
                    next_fgDone = 1'b1;
                end
            end
            ST_RUN: begin
                if (trigRise && !bgMode) begin
                    next_state = ST_FG_CAL;
                    next_fgDone = 1'b0;
                    calStart = 1'b1;
                end else if (bgMode) begin
                    next_state = ST_BG_CAL;
                    calStart = 1'b1;
                end
            end
            ST_BG_CAL: begin
                if (calDone) begin
                    next_state = ST_BG_SWAP;
                end
            end
            ST_BG_SWAP: begin
                if (sampleStrobe) begin
                    // The freed core turns spare; the other active is next.
                    if (!bank) begin
                        next_spare0 = target;
                        next_target = 3'h3 - target - spare0;
                    end else begin
                        next_spare1 = target1;
                        next_target1 = 3'(4'hc - {1'b0, target1}
                            - {1'b0, spare1});
                    end
                    next_bank = !bank;
                    next_state = bgMode ? ST_BG_CAL : ST_RUN;
                    calStart = bgMode;
                end
            end
        endcase
        if (!pend) begin
            next_pend = 1'b1;
            calStart = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= ST_FG_CAL;
            fgDone <= 1'b0;
            trigPrev <= 1'b1;
            pend <= 1'b0;
            spare0 <= 3'h2;
            spare1 <= 3'h3;
            target <= 3'h0;
            target1 <= 3'h4;
            bank <= 1'b0;
        end else begin
            state <= next_state;
            fgDone <= next_fgDone;
            trigPrev <= next_trigPrev;
            pend <= next_pend;
            spare0 <= next_spare0;
            spare1 <= next_spare1;
            target <= next_target;
            target1 <= next_target1;
            bank <= next_bank;
        end
    end

    // ------------------------------------------------------------
    // Output mux and core calibrate enables
    // ------------------------------------------------------------
    logic [CORE_IDX_W-1:0] src [NUM_INPUTS];
    logic [NUM_INPUTS*SAMPLE_W-1:0] next_channelOut;
    logic [NUM_CORES-1:0] next_coreCalibrate;

    // Default owner per input; core 2 or core 3 stands in while the input's home core is the bank's spare.
    function automatic logic [CORE_IDX_W-1:0] owner(
        input int ch,
        input logic [CORE_IDX_W-1:0] s0,
        input logic [CORE_IDX_W-1:0] s1
    );
        logic [CORE_IDX_W-1:0] home;
        home = (ch < 2) ? 3'(ch) : 3'(ch + 2);
        owner = home;
        if (home == 3'h0 && s0 == 3'h0) owner = 3'h2;
        if (home == 3'h1 && s0 == 3'h1) owner = 3'h2;
        if (home == 3'h4 && s1 == 3'h4) owner = 3'h3;
        if (home == 3'h5 && s1 == 3'h5) owner = 3'h3;
    endfunction

    genvar c;
    generate
        for (c = 0; c < NUM_INPUTS; c++) begin : gCh
            assign src[c] = owner(c, spare0, spare1);
        end
    endgenerate

    always_comb begin
        next_channelOut = channelOut;
        next_coreCalibrate = '0;
        if (state == ST_FG_CAL) begin
            next_coreCalibrate = '1;
            next_channelOut = {NUM_INPUTS{MID_CODE}};
        end else if (sampleStrobe) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                next_channelOut[i*SAMPLE_W +: SAMPLE_W] =
                    coreSamples[src[i]*SAMPLE_W +: SAMPLE_W];
            end
        end
        if (state == ST_BG_CAL) begin
            // One spare only; the other active cores keep data.
            next_coreCalibrate[bank ? spare1 : spare0] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            channelOut <= '0;
            coreCalibrate <= '0;
            swapSourceDelayOut <= SWAP_DELAY_RESET;
            swapMuxDelayOut <= SWAP_DELAY_RESET;
        end else begin
            channelOut <= next_channelOut;
            coreCalibrate <= next_coreCalibrate;
            swapSourceDelayOut <= swapSrcDly;
            swapMuxDelayOut <= swapMuxDly;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_FG_MIDCODE: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) state == ST_FG_CAL |=> channelOut == '0)
        else $error("Output not mid-code during calibration.");
    AST_ONE_CORE: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) state != ST_FG_CAL |=> $countones(coreCalibrate) <= 1)
        else $error("More than one core calibrating.");
    AST_NO_FG_BG: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) state == ST_RUN && bgMode |=> state == ST_BG_CAL)
        else $error("Background mode did not start calibration.");
    AST_SWAP_EDGE: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) !sampleStrobe && state != ST_BG_CAL
        |=> $stable(spare0) && $stable(spare1))
        else $error("Core swap off a sample boundary.");
    AST_SPARE_POOL: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) spare0 <= 3'h2 && spare1 >= 3'h3 && spare1 <= 3'h5
        && target != spare0 && target1 != spare1)
        else $error("Spare core left its bank.");
    AST_PREADY: assert property (@(posedge sys_clk) disable iff
        (!rstSync_n) psel && penable && !pready |=> pready)
        else $error("APB answer late.");
endmodule

// ---- core/cal_timer.sv ----
// Cycle counter that times one calibration step.
// Assumes an active-low reset from the parent, asserted asynchronously and released synchronously.
`timescale 1ns/1ps
module cal_timer #(
    parameter int CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic rstSync_n,
    input wire logic start,
    output logic done
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_done;

    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (start) begin
            next_count = 32'(CYCLES);
        end else if (count == 32'h1) begin
            next_count = 32'h0;
            next_done = 1'b1;
        end else if (count != 32'h0) begin
            next_count = count - 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count <= 32'h0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule

// ---- core/trim_bank.sv ----
// Trim storage with factory values loaded at reset, one word per entry.
// Assumes factory values are constant inputs from fuses.
`timescale 1ns/1ps
module trim_bank
    import cal_ctrl_pkg::*;
#(
    parameter int ENTRIES = 18
) (
    input wire logic sys_clk,
    input wire logic rstSync_n,
    input wire logic [ENTRIES*TRIM_W-1:0] factoryTrim,
    input wire logic wrEn,
    input wire logic [4:0] wrIdx,
    input wire logic [TRIM_W-1:0] wrData,
    input wire logic [4:0] rdIdx,
    output logic [TRIM_W-1:0] rdData,
    output logic [ENTRIES*TRIM_W-1:0] trimOut
);
    logic [TRIM_W-1:0] mem [ENTRIES];
    logic loaded;

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            loaded <= 1'b0;
        end else begin
            loaded <= 1'b1;
        end
    end

    // Factory values are copied on the first clock after reset release.
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : gEntry
            always_ff @(posedge sys_clk) begin
                if (!loaded) begin
                    mem[g] <= factoryTrim[g*TRIM_W +: TRIM_W];
                end else if (wrEn && wrIdx == 5'(g)) begin
                    mem[g] <= wrData;
                end
            end
            assign trimOut[g*TRIM_W +: TRIM_W] = mem[g];
        end
    endgenerate

    always_comb begin
        rdData = '0;
        if (rdIdx < 5'(ENTRIES)) begin
            rdData = mem[rdIdx];
        end
    end
endmodule

// ---- pkg/cal_ctrl_pkg.sv ----
// Package with register map, field layout, reset values and timing for the
// converter calibration controller.
// Assumes a 32-bit APB with word-aligned registers.
package cal_ctrl_pkg;

    localparam int NUM_CORES = 6;
    localparam int NUM_INPUTS = 4;
    localparam int SAMPLE_W = 12;
    localparam int CORE_IDX_W = 3;

    // Printed offsets are not multiples of four: they are word indices.
    localparam logic [7:0] IDX_SWAP_SOURCE_DELAY = 8'h9a;
    localparam logic [7:0] IDX_SWAP_MUX_DELAY = 8'h9b;
    localparam logic [7:0] IDX_CAL_CONTROL = 8'h90;
    localparam logic [7:0] IDX_CAL_STATUS = 8'h91;
    localparam logic [7:0] IDX_TRIM_BASE = 8'ha0;
    localparam logic [7:0] IDX_TRIM_LAST = 8'hb1;

    // Calibration control fields.
    localparam int CTL_SOFT_TRIG = 0;
    localparam int CTL_SRC_SEL = 1;
    localparam int CTL_BG_EN = 2;
    localparam logic [2:0] CTL_RESET = 3'h0;

    // Calibration status fields.
    localparam int STS_FG_DONE = 0;
    localparam int STS_BUSY = 1;
    localparam int STS_SPARE_LO = 4;
    localparam int STS_SPARE_HI = 6;
    localparam int STS_TARGET_LO = 8;
    localparam int STS_TARGET_HI = 10;

    localparam logic [7:0] SWAP_DELAY_RESET = 8'h00;
    localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h000;

    // Trim kinds, one word per (core, kind).
    localparam int TRIM_KINDS = 3;
    localparam int TRIM_W = 8;

    // Time a single core calibration takes.
    localparam int CAL_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_FG_CAL = 2'b00,
        ST_RUN = 2'b01,
        ST_BG_CAL = 2'b10,
        ST_BG_SWAP = 2'b11
    } cal_state_e;

endpackage

// ---- verification/adc_core_calibration_control_tb.sv ----
// Self-checking testbench for the converter calibration controller.
// Assumes the package is compiled first and APB runs on sys_clk.
`timescale 1ns/1ps
module adc_core_calibration_control_tb
    import cal_ctrl_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int CAL = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cal_trigger_pin = 1'b0;
    logic sampleStrobe = 1'b0;
    logic [NUM_CORES*SAMPLE_W-1:0] coreSamples;
    logic [18*TRIM_W-1:0] factoryTrim;
    logic [NUM_INPUTS*SAMPLE_W-1:0] channelOut;
    logic [NUM_CORES-1:0] coreCalibrate;
    logic [18*TRIM_W-1:0] trimOut;
    logic [7:0] swapSourceDelayOut;
    logic [7:0] swapMuxDelayOut;
    int errors = 0;
    int checksDone = 0;
    int cycles = 0;
    int n;
    logic [1:0] strobeCnt = 2'h0;
    logic [1:0] strobeHist = 2'h0;
    logic bgWatch = 1'b0;
    logic [NUM_CORES-1:0] seenCal = 6'h00;
    logic [NUM_INPUTS*SAMPLE_W-1:0] lastOut;
    logic [31:0] rd;
    logic err;

    adc_core_calibration_control #(.CAL_LEN(CAL)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .cal_trigger_pin(cal_trigger_pin), .sampleStrobe(sampleStrobe),
        .coreSamples(coreSamples), .factoryTrim(factoryTrim),
        .channelOut(channelOut), .coreCalibrate(coreCalibrate),
        .trimOut(trimOut), .swapSourceDelayOut(swapSourceDelayOut),
        .swapMuxDelayOut(swapMuxDelayOut)
    );

    // ------------------------------------------------------------------
    // Clock, sample strobe and timeout
    // ------------------------------------------------------------------
    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        strobeCnt <= strobeCnt + 2'h1;
        sampleStrobe <= (strobeCnt == 2'h3);
        strobeHist <= {strobeHist[0], sampleStrobe};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] samp(input int k);
        return 12'(12'h111 * (k + 1));
    endfunction

    function automatic int coreOf(input logic [11:0] ch);
        for (int k = 0; k < NUM_CORES; k++) begin
            if (ch === samp(k)) return k;
        end
        return -1;
    endfunction

    task automatic check(input string what, input logic [143:0] seen,
            input logic [143:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
            input logic [31:0] wd, output logic [31:0] rdat,
            output logic rerr);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitCal(input logic [5:0] v, input int lim,
            output int cnt);
        cnt = 0;
        while (coreCalibrate !== v && cnt < lim) begin
            @(negedge sys_clk);
            cnt++;
        end
        check("coreCalibrate", coreCalibrate, v);
    endtask

    task automatic checkMap();
        int map [4] = '{0, 1, 4, 5};
        @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            check("fgMap", channelOut[i*12+:12], samp(map[i]));
        end
    endtask

    task automatic fgRun();
        int c;
        waitCal(6'h3f, 20, c);
        check("fgMidCode", channelOut, {4{MID_CODE}});
        waitCal(6'h00, CAL + 20, c);
        check("fgLength", c >= CAL - 1, 1'b1);
        repeat (10) @(posedge sys_clk);
        checkMap();
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Background monitor
    // ------------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (bgWatch) begin
            seenCal = seenCal | coreCalibrate;
            check("oneCal", $countones(coreCalibrate) <= 1, 1'b1);
            for (int i = 0; i < 4; i++) begin
                n = coreOf(channelOut[i*12+:12]);
                check("srcCore", n >= 0 && (i < 2) == (n < 3), 1'b1);
                check("srcLive", n >= 0 && !coreCalibrate[n], 1'b1);
            end
            if (channelOut !== lastOut) begin
                check("swapAtStrobe", |strobeHist, 1'b1);
            end
        end
        lastOut = channelOut;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int k = 0; k < NUM_CORES; k++) coreSamples[k*12+:12] = samp(k);
        for (int i = 0; i < 18; i++) factoryTrim[i*8+:8] = 8'h30 + 8'(i);
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        waitCal(6'h3f, 10, n);
        check("pupMidCode", channelOut, {4{MID_CODE}});
        waitCal(6'h00, CAL + 20, n);
        repeat (10) @(posedge sys_clk);
        checkMap();
        $display("test power-up done");

        apb(1'b0, IDX_CAL_STATUS, 32'h0, rd, err);
        check("fgDone", rd[STS_FG_DONE], 1'b1);
        check("busy", rd[STS_BUSY], 1'b0);
        apb(1'b1, IDX_CAL_STATUS, 32'h3, rd, err);
        check("statusWrErr", err, 1'b1);
        apb(1'b0, 8'h00, 32'h0, rd, err);
        check("unmappedErr", err, 1'b1);
        apb(1'b0, IDX_SWAP_SOURCE_DELAY, 32'h0, rd, err);
        check("srcDlyReset", rd[7:0], SWAP_DELAY_RESET);
        apb(1'b1, IDX_SWAP_SOURCE_DELAY, 32'h1f, rd, err);
        apb(1'b1, IDX_SWAP_MUX_DELAY, 32'h1e, rd, err);
        apb(1'b0, IDX_SWAP_SOURCE_DELAY, 32'h0, rd, err);
        check("srcDly", rd[7:0], 8'h1f);
        apb(1'b0, IDX_SWAP_MUX_DELAY, 32'h0, rd, err);
        check("muxDly", rd[7:0], 8'h1e);
        check("dlyOuts", {swapSourceDelayOut, swapMuxDelayOut},
            16'h1f1e);
        $display("test registers done");

        check("trimOutReset", trimOut, factoryTrim);
        for (int i = 0; i < 18; i++) begin
            apb(1'b0, IDX_TRIM_BASE + 8'(i), 32'h0, rd, err);
            check("trimRead", rd[7:0], 8'h30 + 8'(i));
        end
        apb(1'b1, IDX_TRIM_BASE + 8'h05, 32'hc5, rd, err);
        apb(1'b0, IDX_TRIM_BASE + 8'h05, 32'h0, rd, err);
        check("trimWrite", rd[7:0], 8'hc5);
        check("trimOutOwn", trimOut[47:32], 16'hc534);
        $display("test trims done");

        apb(1'b1, IDX_CAL_CONTROL, 32'h2, rd, err);
        apb(1'b1, IDX_CAL_CONTROL, 32'h3, rd, err);
        repeat (CAL) @(negedge sys_clk);
        check("softIgnored", coreCalibrate, 6'h00);
        @(posedge sys_clk);
        cal_trigger_pin <= 1'b1;
        fgRun();
        apb(1'b1, IDX_CAL_CONTROL, 32'h0, rd, err);
        apb(1'b1, IDX_CAL_CONTROL, 32'h1, rd, err);
        fgRun();
        @(posedge sys_clk);
        cal_trigger_pin <= 1'b0;
        @(posedge sys_clk);
        cal_trigger_pin <= 1'b1;
        repeat (CAL) @(negedge sys_clk);
        check("pinIgnored", coreCalibrate, 6'h00);
        $display("test triggers done");

        apb(1'b1, IDX_CAL_CONTROL, 32'h0, rd, err);
        apb(1'b1, IDX_CAL_CONTROL, 32'h5, rd, err);
        repeat (20) @(posedge sys_clk);
        bgWatch = 1'b1;
        repeat (600) @(posedge sys_clk);
        bgWatch = 1'b0;
        check("allCoresCal", seenCal, 6'h3f);
        $display("test background done");
        conclude();
    end
endmodule
